/* common/lvh_pkg.sv */
// Purpose: shared constants for the hypervisor virtual interface control
// Assumes: 64-bit system register data, sixteen list entry slots
// Notes:   field positions and offsets are named once here
package lvh_pkg;
  // system register encoding of the control register and list entries
  localparam logic [1:0] ENC_OP0      = 2'h3;
  localparam logic [2:0] ENC_OP1      = 3'h4;
  localparam logic [3:0] ENC_CRN      = 4'hC;
  localparam logic [3:0] ENC_CRM_CTRL = 4'hB;
  localparam logic [2:0] ENC_OP2_CTRL = 3'h0;
  localparam logic [2:0] ENC_CRM_LIST = 3'h6;  // crm[3:1], crm[0] is n[3]
  // redirect memory offsets
  localparam logic [11:0] MEM_CTRL     = 12'h4C0;
  localparam logic [11:0] MEM_LIST     = 12'h400;
  localparam int          MEM_LIST_STEP = 8;
  // trap class code
  localparam logic [5:0] TRAP_CLASS = 6'h18;
  // privilege levels
  localparam logic [1:0] LVL_USER = 2'h0;
  localparam logic [1:0] LVL_OS   = 2'h1;
  localparam logic [1:0] LVL_HYP  = 2'h2;
  localparam logic [1:0] LVL_MON  = 2'h3;
  // control register fields
  localparam int CNT_HI = 31;
  localparam int CNT_LO = 27;
  localparam int B_INJ_MASK = 15;
  localparam int B_TRAP_DIR = 14;
  localparam int B_TRAP_SEI = 13;
  localparam int B_TRAP_G1  = 12;
  localparam int B_TRAP_G0  = 11;
  localparam int B_TRAP_SHARED = 10;
  localparam int MAINT_HI   = 7;
  localparam int MAINT_LO   = 1;
  localparam int B_EN       = 0;
  // writable control bits, older-arch-only bits added separately
  localparam logic [63:0] CTRL_RW_MASK   = 64'h0000_0000_F800_5CFF;
  localparam logic [63:0] CTRL_OLD_MASK  = 64'h0000_0000_0000_A000;
  localparam logic [63:0] CTRL_RESET     = 64'h0;
  // list entry fields
  localparam int B_MAPS_PHYS = 61;
  localparam int B_EOI_REQ   = 41;
  localparam int PID_HI = 44;
  localparam int PID_LO = 32;
  localparam logic [63:0] LIST_RSV_MASK  = 64'h0700_E000_0000_0000;
  localparam logic [63:0] LIST_PRIO_LOW  = 64'h0007_0000_0000_0000;
  localparam int          LIST_SLOTS     = 16;
  // implemented private peripheral id bits and reachable count
  localparam int          PRIV_ID_BITS = 5;
  localparam logic [12:0] PRIV_COUNT   = 13'h0020;
  // outcome of a register access
  typedef enum logic [1:0] {
    LVH_DONE, LVH_UNDEF, LVH_TRAP, LVH_REDIR
  } lvh_outcome_t;
endpackage

/* dv/lvh_core_model.sv */
// Purpose: core side model issuing guest checks and deactivations
// Assumes: each event is a one-cycle pulse launched just after an edge
// Notes:   the bench top calls the tasks; released lines show inverses
module lvh_core_model (
  // clock
  input  wire logic       core_clk,
  // guest interface access to be checked
  output logic            guest_valid,
  output logic            guest_write,
  output logic [3:0]      guest_kind,  // deact, g0, g1, shared
  // guest deactivation
  output logic            deact_event,
  output logic [3:0]      deact_slot
);
  timeunit 1ns;
  timeprecision 1ns;
  // quiet at time zero
  initial begin
    guest_valid = 1'h0;
    guest_write = 1'h0;
    guest_kind  = 4'h0;
    deact_event = 1'h0;
    deact_slot  = 4'h0;
  end
  // one level-1 guest access, kind held until the taking edge
  task automatic guest(input logic w, input logic [3:0] k);
    @(posedge core_clk);
    #1 guest_valid = 1'h1;
    guest_write = w;
    guest_kind  = k;
    @(posedge core_clk);
    #1 guest_valid = 1'h0;
    guest_kind  = ~k;  // stale kind must not look valid
    guest_write = ~w;
  endtask
  // one deactivation of a list slot
  task automatic deact(input logic [3:0] s);
    @(posedge core_clk);
    #1 deact_event = 1'h1;
    deact_slot  = s;
    @(posedge core_clk);
    #1 deact_event = 1'h0;
    deact_slot  = ~s;
  endtask
endmodule // lvh_core_model

/* dv/lvh_ctrl_tb_top.sv */
// Purpose: self-checking bench for the hypervisor interface control
// Assumes: inputs change 1 ns after the rising edge
// Notes:   pulses are caught by sticky flags, cleared before each event
module lvh_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // clock, reset, access request
  logic        core_clk = 1'h0, rst = 1'h1, clk_en = 1'h1;
  logic        acc_valid = 1'h0, acc_write = 1'h0;
  logic [1:0]  acc_level = 2'h2, acc_op0 = 2'h3;
  logic [2:0]  acc_op1 = 3'h4, acc_op2 = 3'h0;
  logic [3:0]  acc_crn = 4'hC, acc_crm = 4'hB;
  logic [63:0] acc_wdata = 64'h0;
  // configuration levels
  logic el2_implemented = 1'h1, el2_enabled = 1'h1;
  logic nested_virt_enable = 1'h0, nested_redirect_enable = 1'h0;
  logic legacy_mode_select = 1'h1, older_arch_config = 1'h0;
  logic legacy_only_config = 1'h0;
  logic sysreg_iface_enable_hyp = 1'h1, sysreg_iface_enable_mon = 1'h1;
  logic [4:0]  list_entry_count = 5'h10;
  // partner lines and design outputs
  logic        guest_valid, guest_write, deact_event;
  logic [3:0]  guest_kind, deact_slot;
  logic        resp_valid, eff_enable, eff_injected_mask, eff_trap_sei;
  logic        guest_trap, phys_deact_valid, eoi_maint;
  lvh_pkg::lvh_outcome_t resp_outcome;
  logic [1:0]  resp_trap_level;
  logic [5:0]  resp_class;
  logic [11:0] resp_mem_offset;
  logic [63:0] resp_rdata;
  logic [6:0]  eff_maint_enable;
  logic [12:0] phys_deact_id, seen_id;
  // sticky pulse flags and counters
  logic saw_resp, saw_trap, saw_phys, saw_eoi;
  int   mismatches = 0, check_count = 0;

  always #20 core_clk = ~core_clk;

  lvh_core_model core_u (.core_clk, .guest_valid, .guest_write,
    .guest_kind, .deact_event, .deact_slot);

  lvh_ctrl dut_u (.core_clk, .rst, .clk_en, .acc_valid, .acc_write,
    .acc_level, .acc_op0, .acc_op1, .acc_crn, .acc_crm, .acc_op2,
    .acc_wdata, .el2_implemented, .el2_enabled, .nested_virt_enable,
    .nested_redirect_enable, .legacy_mode_select, .older_arch_config,
    .legacy_only_config, .sysreg_iface_enable_hyp,
    .sysreg_iface_enable_mon, .list_entry_count, .guest_valid,
    .guest_write, .guest_is_deact(guest_kind[3]),
    .guest_is_g0(guest_kind[2]), .guest_is_g1(guest_kind[1]),
    .guest_is_shared(guest_kind[0]), .deact_event, .deact_slot,
    .resp_valid, .resp_outcome, .resp_trap_level, .resp_class,
    .resp_mem_offset, .resp_rdata, .eff_enable, .eff_maint_enable,
    .eff_injected_mask, .eff_trap_sei, .guest_trap, .phys_deact_valid,
    .phys_deact_id, .eoi_maint);

  // catch one-cycle pulses so checks need not hit the exact cycle
  always @(posedge core_clk) begin
    if (resp_valid === 1'h1) saw_resp <= 1'h1;
    if (guest_trap === 1'h1) saw_trap <= 1'h1;
    if (eoi_maint === 1'h1) saw_eoi <= 1'h1;
    if (phys_deact_valid === 1'h1) begin
      saw_phys <= 1'h1;
      seen_id  <= phys_deact_id;
    end
  end

  task automatic clr();
    {saw_resp, saw_trap, saw_phys, saw_eoi, seen_id} = '0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one register access; answer is sampled just after the taking edge
  task automatic acc(input logic w, input logic [1:0] l,
    input logic [3:0] m, input logic [2:0] o2, input logic [63:0] d);
    @(posedge core_clk);
    #1 acc_valid = 1'h1;
    acc_write = w;
    acc_level = l;
    acc_crm   = m;
    acc_op2   = o2;
    acc_wdata = d;
    @(posedge core_clk);
    #1 acc_valid = 1'h0;
    acc_wdata = ~d;
  endtask
  // read with a given nesting setup and check valid, outcome, class and offset
  task automatic try(input logic [1:0] l, input logic nv, input logic nv2,
    input logic [3:0] m, input logic [2:0] o2,
    input lvh_pkg::lvh_outcome_t e, input logic [11:0] off);
    nested_virt_enable = nv;
    nested_redirect_enable = nv2;
    acc(1'h0, l, m, o2, 64'h0);
    chk({resp_valid, resp_outcome, resp_class, resp_mem_offset},
        {1'h1, e, (e == lvh_pkg::LVH_TRAP) ? 6'h18 : 6'h0, off});
  endtask
  // verdict, reached from the main sequence and the watchdog
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #(40 * 4000);
    mismatches++;
    test_done();
  end

  initial begin
    clr();
    idle(8);
    rst = 1'h0;
    // control register reset, mask and effective values
    acc(1'h0, 2'h2, 4'hB, 3'h0, 64'h0);
    chk(resp_rdata, 64'h0);
    acc(1'h1, 2'h2, 4'hB, 3'h0, '1);
    acc(1'h0, 2'h2, 4'hB, 3'h0, 64'h0);
    chk(resp_rdata, 64'h0000_0000_F800_5CFF);
    idle(2);
    chk({eff_enable, eff_maint_enable, eff_trap_sei}, 9'h1FE);
    older_arch_config = 1'h1;
    acc(1'h1, 2'h2, 4'hB, 3'h0, '1);
    acc(1'h0, 2'h2, 4'hB, 3'h0, 64'h0);
    chk(resp_rdata, 64'h0000_0000_F800_FCFF);
    idle(2);
    chk({eff_enable, eff_trap_sei, eff_injected_mask}, 3'h7);
    legacy_mode_select = 1'h0;
    idle(2);
    chk({eff_enable, eff_maint_enable, eff_trap_sei}, 9'h0);
    $display("test control register done");
    // guest traps per kind, with and without legacy select
    for (int s = 0; s < 2; s++) begin
      legacy_mode_select = s[0];
      for (int i = 0; i < 4; i++) begin
        clr();
        core_u.guest(1'h1, 4'h1 << i);
        idle(2);
        chk(saw_trap, s[0]);
      end
    end
    clr();
    core_u.guest(1'h0, 4'h8);
    idle(2);
    chk(saw_trap, 1'h0);
    $display("test guest traps done");
    // access outcomes in decision order
    legacy_mode_select = 1'h0;
    try(2'h0, 1'h1, 1'h1, 4'hB, 3'h0, lvh_pkg::LVH_UNDEF, 12'h0);
    try(2'h1, 1'h1, 1'h1, 4'hB, 3'h0, lvh_pkg::LVH_REDIR, 12'h4C0);
    try(2'h1, 1'h1, 1'h1, 4'hD, 3'h1, lvh_pkg::LVH_REDIR, 12'h448);
    try(2'h1, 1'h1, 1'h0, 4'hB, 3'h0, lvh_pkg::LVH_TRAP, 12'h0);
    chk(resp_trap_level, 2'h2);
    try(2'h1, 1'h0, 1'h0, 4'hB, 3'h0, lvh_pkg::LVH_UNDEF, 12'h0);
    nested_virt_enable = 1'h1;
    nested_redirect_enable = 1'h1;
    acc(1'h1, 2'h1, 4'hB, 3'h0, 64'h0);
    acc(1'h0, 2'h2, 4'hB, 3'h0, 64'h0);
    chk(resp_rdata, 64'h0000_0000_F800_FCFF);
    list_entry_count = 5'h09;
    try(2'h2, 1'h0, 1'h0, 4'hD, 3'h1, lvh_pkg::LVH_UNDEF, 12'h0);
    list_entry_count = 5'h10;
    sysreg_iface_enable_hyp = 1'h0;
    try(2'h2, 1'h0, 1'h0, 4'hB, 3'h0, lvh_pkg::LVH_TRAP, 12'h0);
    sysreg_iface_enable_mon = 1'h0;
    try(2'h3, 1'h0, 1'h0, 4'hB, 3'h0, lvh_pkg::LVH_TRAP, 12'h0);
    chk(resp_trap_level, 2'h3);
    {sysreg_iface_enable_hyp, sysreg_iface_enable_mon} = 2'h3;
    acc(1'h0, 2'h2, 4'hA, 3'h0, 64'h0);
    clr();
    idle(1);
    chk(saw_resp, 1'h0);
    $display("test access outcomes done");
    // deactivation counter wraps after 32, slot effects need el2
    acc(1'h1, 2'h2, 4'hC, 3'h0, 64'h2000_0003_0000_0000);
    acc(1'h1, 2'h2, 4'hB, 3'h0, 64'h0);
    el2_enabled = 1'h0;
    clr();
    repeat (33) core_u.deact(4'h0);
    idle(2);
    chk({saw_phys, saw_eoi}, 2'h0);
    acc(1'h0, 2'h2, 4'hB, 3'h0, 64'h0);
    chk(resp_rdata, 64'h0000_0000_0800_0000);
    el2_enabled = 1'h1;
    $display("test deactivation counter done");
    // list entry deactivation effects
    acc(1'h1, 2'h2, 4'hC, 3'h3, 64'h2000_0005_0000_0021);
    acc(1'h1, 2'h2, 4'hC, 3'h4, 64'h0000_0200_0000_0022);
    acc(1'h1, 2'h2, 4'hC, 3'h5, 64'h2000_0028_0000_0023);
    clr();
    core_u.deact(4'h3);
    idle(2);
    chk({saw_phys, seen_id}, {1'h1, 13'h0005});
    clr();
    core_u.deact(4'h4);
    idle(2);
    chk({saw_phys, saw_eoi}, 2'h1);
    clr();
    core_u.deact(4'h5);
    idle(2);
    chk({saw_phys, saw_eoi}, 2'h0);
    // list entry reserved bits, then legacy-only shaping
    acc(1'h1, 2'h2, 4'hC, 3'h6, '1);
    acc(1'h0, 2'h2, 4'hC, 3'h6, 64'h0);
    chk(resp_rdata, 64'hF8FF_1FFF_FFFF_FFFF);
    legacy_only_config = 1'h1;
    acc(1'h1, 2'h2, 4'hC, 3'h6, '1);
    acc(1'h0, 2'h2, 4'hC, 3'h6, 64'h0);
    chk(resp_rdata, 64'hF8F8_001F_FFFF_FFFF);
    el2_implemented = 1'h0;
    acc(1'h0, 2'h3, 4'hC, 3'h6, 64'h0);
    chk(resp_rdata, 64'h0);
    $display("test list entries done");
    test_done();
  end
endmodule // lvh_ctrl_tb_top

/* verilog/lvh_access_check.sv */
// Purpose: decide the outcome of one system register access
// Assumes: purely combinational, shared by both register kinds
// Notes:   checks follow a fixed priority order, top to bottom
module lvh_access_check (
  // access context
  input  wire logic [1:0]           level,
  input  wire logic                 slot_missing,
  // configuration state
  input  wire logic                 el2_enabled,
  input  wire logic                 nested_virt_enable,
  input  wire logic                 nested_redirect_enable,
  input  wire logic                 legacy_mode_select,
  input  wire logic                 older_arch_config,
  input  wire logic                 sre_hyp,
  input  wire logic                 sre_mon,
  // decision
  output lvh_pkg::lvh_outcome_t     outcome,
  output logic [1:0]                trap_level
);
  // one priority chain; trap level only matters for a trap
  always_comb begin
    outcome    = lvh_pkg::LVH_DONE;
    trap_level = lvh_pkg::LVL_HYP;
    if (slot_missing) begin
      outcome = lvh_pkg::LVH_UNDEF;  // R14
    end else if (level == lvh_pkg::LVL_USER) begin
      outcome = lvh_pkg::LVH_UNDEF;  // R10
    end else if (level == lvh_pkg::LVL_OS) begin
      if (el2_enabled && nested_redirect_enable && nested_virt_enable &&
          !legacy_mode_select) begin
        outcome = lvh_pkg::LVH_REDIR;  // R11
      end else if (el2_enabled && nested_virt_enable &&
                   !legacy_mode_select) begin
        outcome = lvh_pkg::LVH_TRAP;  // R12
      end else begin
        outcome = lvh_pkg::LVH_UNDEF;  // R12
      end
    end else if (level == lvh_pkg::LVL_HYP) begin
      if (older_arch_config && !sre_hyp) begin
        outcome = lvh_pkg::LVH_TRAP;  // R13
      end
    end else begin
      trap_level = lvh_pkg::LVL_MON;
      if (older_arch_config && !sre_mon) begin
        outcome = lvh_pkg::LVH_TRAP;  // R13
      end
    end
  end
endmodule // lvh_access_check

/* verilog/lvh_ctrl.sv */
// Purpose: hypervisor control register and list entries of a virtual
//          cpu interface, reached as system registers
// Assumes: one access offered per cycle, answered one cycle later
// Notes:   list entries are not reset, so their contents start unknown
//
// How it works
// R1: guest deactivation bumps five-bit counter
// R2: legacy select low zeroes traps, enables
// R3: deactivate-trap bit traps level-1 deactivate writes
// R4: group one trap-all traps level-1 accesses
// R5: group zero trap-all traps level-1 accesses
// R6: shared-register trap bit traps level-1 accesses
// R7: bits 15, 13 only in older config
// R8: seven maintenance enables at bits 7..1
// R9: bit 0 is interface global enable
// R10: control encoding decoded; lowest level undefined
// R11: nested redirect sends control to 0x4C0
// R12: nested enable alone traps, class 0x18
// R13: upper levels trap if interface disabled, in older config only
// R14: list encoding decode; missing slot undefined
// R15: list redirect offset 0x400 plus 8n
// R16: mapped entry deactivates its physical interrupt
// R17: mapped bit has no reset value
// R18: legacy config keeps five priority bits
// R19: unmapped bit 41 requests maintenance on deactivate
// R20: mapped id names reachable private interrupt
// R21: no effect without hypervisor; zero reads
// R22: reserved bits read zero, writes ignored
module lvh_ctrl (
  // clock, reset, enable
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  // system register access
  input  wire logic                 acc_valid,
  input  wire logic                 acc_write,
  input  wire logic [1:0]           acc_level,
  input  wire logic [1:0]           acc_op0,
  input  wire logic [2:0]           acc_op1,
  input  wire logic [3:0]           acc_crn,
  input  wire logic [3:0]           acc_crm,
  input  wire logic [2:0]           acc_op2,
  input  wire logic [63:0]          acc_wdata,
  // configuration state from the core
  input  wire logic                 el2_implemented,
  input  wire logic                 el2_enabled,
  input  wire logic                 nested_virt_enable,
  input  wire logic                 nested_redirect_enable,
  input  wire logic                 legacy_mode_select,
  input  wire logic                 older_arch_config,
  input  wire logic                 legacy_only_config,
  input  wire logic                 sysreg_iface_enable_hyp,
  input  wire logic                 sysreg_iface_enable_mon,
  input  wire logic [4:0]           list_entry_count,
  // guest interface accesses to be checked for traps
  input  wire logic                 guest_valid,
  input  wire logic                 guest_write,
  input  wire logic                 guest_is_deact,
  input  wire logic                 guest_is_g0,
  input  wire logic                 guest_is_g1,
  input  wire logic                 guest_is_shared,
  // guest deactivation event
  input  wire logic                 deact_event,
  input  wire logic [3:0]           deact_slot,
  // access answer
  output logic                      resp_valid,
  output lvh_pkg::lvh_outcome_t     resp_outcome,
  output logic [1:0]                resp_trap_level,
  output logic [5:0]                resp_class,
  output logic [11:0]               resp_mem_offset,
  output logic [63:0]               resp_rdata,
  // effective controls
  output logic                      eff_enable,
  output logic [6:0]                eff_maint_enable,
  output logic                      eff_injected_mask,
  output logic                      eff_trap_sei,
  output logic                      guest_trap,
  // deactivation effects
  output logic                      phys_deact_valid,
  output logic [12:0]               phys_deact_id,
  output logic                      eoi_maint
);
  logic [63:0] ctrl;                          // control register
  logic [63:0] list_entry [lvh_pkg::LIST_SLOTS]; // list entries, no reset
  logic        hit_ctrl, hit_list, slot_missing;
  logic [3:0]  slot;
  lvh_pkg::lvh_outcome_t outcome;
  logic [1:0]  trap_level;
  logic        take, wr_ctrl, wr_list;
  logic [63:0] ctrl_mask, next_ctrl, next_list;
  logic [4:0]  next_count;
  logic [63:0] sel_entry;
  logic        deact_ok;

  // decode of the two encodings
  assign hit_ctrl = acc_op0 == lvh_pkg::ENC_OP0 &&
                    acc_op1 == lvh_pkg::ENC_OP1 &&
                    acc_crn == lvh_pkg::ENC_CRN &&
                    acc_crm == lvh_pkg::ENC_CRM_CTRL &&
                    acc_op2 == lvh_pkg::ENC_OP2_CTRL;  // R10
  assign hit_list = acc_op0 == lvh_pkg::ENC_OP0 &&
                    acc_op1 == lvh_pkg::ENC_OP1 &&
                    acc_crn == lvh_pkg::ENC_CRN &&
                    acc_crm[3:1] == lvh_pkg::ENC_CRM_LIST;  // R14
  assign slot = {acc_crm[0], acc_op2};  // R14
  assign slot_missing = hit_list && {1'b0, slot} >= list_entry_count;

  // outcome decision shared by both register kinds
  lvh_access_check u_check (
    .level                  (acc_level),
    .slot_missing           (slot_missing),
    .el2_enabled            (el2_enabled),
    .nested_virt_enable     (nested_virt_enable),
    .nested_redirect_enable (nested_redirect_enable),
    .legacy_mode_select     (legacy_mode_select),
    .older_arch_config      (older_arch_config),
    .sre_hyp                (sysreg_iface_enable_hyp),
    .sre_mon                (sysreg_iface_enable_mon),
    .outcome                (outcome),
    .trap_level             (trap_level)
  );

  // other encodings belong to other blocks and get no answer here
  assign take    = clk_en && acc_valid && (hit_ctrl || hit_list);
  assign wr_ctrl = take && hit_ctrl && acc_write &&
                   outcome == lvh_pkg::LVH_DONE;
  assign wr_list = take && hit_list && acc_write &&
                   outcome == lvh_pkg::LVH_DONE;

  // writable bits: older-arch bits exist only in that configuration
  assign ctrl_mask = lvh_pkg::CTRL_RW_MASK |
                     (older_arch_config ? lvh_pkg::CTRL_OLD_MASK : 64'h0);

  // control write with counter bump; a bump in the write cycle still counts
  always_comb begin
    next_ctrl = wr_ctrl ? (acc_wdata & ctrl_mask) : ctrl;  // R22 R7
    next_count = next_ctrl[lvh_pkg::CNT_HI:lvh_pkg::CNT_LO];
    if (deact_event) begin
      next_count = next_count + 5'h01;  // R1
    end
    next_ctrl[lvh_pkg::CNT_HI:lvh_pkg::CNT_LO] = next_count;
  end

  // control register state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl <= lvh_pkg::CTRL_RESET;
    end else if (clk_en) begin
      ctrl <= next_ctrl;
    end
  end

  // sanitise a list entry write before it is stored
  always_comb begin
    next_list = acc_wdata & ~lvh_pkg::LIST_RSV_MASK;  // R22
    if (legacy_only_config) begin
      next_list = next_list & ~lvh_pkg::LIST_PRIO_LOW;  // R18
      if (acc_wdata[lvh_pkg::B_MAPS_PHYS]) begin
        // only enough id bits for the implemented private interrupts
        next_list[lvh_pkg::PID_HI:lvh_pkg::PID_LO] =
          {{(13 - lvh_pkg::PRIV_ID_BITS){1'b0}},
           acc_wdata[lvh_pkg::PID_LO +: lvh_pkg::PRIV_ID_BITS]};  // R20
      end else begin
        next_list[lvh_pkg::PID_HI:lvh_pkg::PID_LO] = 13'h0000;
        next_list[lvh_pkg::B_EOI_REQ] = acc_wdata[lvh_pkg::B_EOI_REQ]; // R19
      end
    end
  end

  // list entries carry no reset, the mapped bit stays unknown
  always_ff @(posedge core_clk) begin
    if (clk_en && wr_list) begin
      list_entry[slot] <= next_list;  // R17
    end
  end

  // answer to an access, one cycle after it is taken
  always_ff @(posedge core_clk) begin
    if (rst) begin
      resp_valid      <= 1'b0;
      resp_outcome    <= lvh_pkg::LVH_DONE;
      resp_trap_level <= 2'h0;
      resp_class      <= 6'h00;
      resp_mem_offset <= 12'h000;
      resp_rdata      <= 64'h0;
    end else if (clk_en) begin
      resp_valid      <= take;
      resp_outcome    <= outcome;
      resp_trap_level <= trap_level;
      resp_class      <= outcome == lvh_pkg::LVH_TRAP ?
                         lvh_pkg::TRAP_CLASS : 6'h00;  // R12 R13
      if (outcome != lvh_pkg::LVH_REDIR) begin
        resp_mem_offset <= 12'h000;
      end else if (hit_ctrl) begin
        resp_mem_offset <= lvh_pkg::MEM_CTRL;  // R11
      end else begin
        resp_mem_offset <= lvh_pkg::MEM_LIST +
          12'(lvh_pkg::MEM_LIST_STEP * slot);  // R15
      end
      // monitor read with no hypervisor level sees zero
      if (!take || acc_write || outcome != lvh_pkg::LVH_DONE ||
          (acc_level == lvh_pkg::LVL_MON && !el2_implemented)) begin
        resp_rdata <= 64'h0;  // R21
      end else if (hit_ctrl) begin
        // bits kept from an older-config write vanish once it is off
        resp_rdata <= ctrl & ctrl_mask;  // R7
      end else begin
        resp_rdata <= list_entry[slot];
      end
    end
  end

  // effective controls: legacy select low forces all but the injected mask off
  always_ff @(posedge core_clk) begin
    if (rst) begin
      eff_enable        <= 1'b0;
      eff_maint_enable  <= 7'h00;
      eff_injected_mask <= 1'b0;
      eff_trap_sei      <= 1'b0;
    end else if (clk_en) begin
      eff_enable <= legacy_mode_select && ctrl[lvh_pkg::B_EN];  // R2 R9
      eff_maint_enable <= legacy_mode_select ?
        ctrl[lvh_pkg::MAINT_HI:lvh_pkg::MAINT_LO] : 7'h00;  // R2 R8
      eff_injected_mask <= older_arch_config &&
                           ctrl[lvh_pkg::B_INJ_MASK];  // R7
      eff_trap_sei <= legacy_mode_select && older_arch_config &&
                      ctrl[lvh_pkg::B_TRAP_SEI];  // R7
    end
  end

  // guest access trap check, answered one cycle later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      guest_trap <= 1'b0;
    end else if (clk_en) begin
      guest_trap <= guest_valid && legacy_mode_select && (  // R2
        (guest_write && guest_is_deact && ctrl[lvh_pkg::B_TRAP_DIR]) || // R3
        (guest_is_g1 && ctrl[lvh_pkg::B_TRAP_G1]) ||  // R4
        (guest_is_g0 && ctrl[lvh_pkg::B_TRAP_G0]) ||  // R5
        (guest_is_shared && ctrl[lvh_pkg::B_TRAP_SHARED]));  // R6
    end
  end

  // deactivation side effects, only with the hypervisor level enabled
  assign sel_entry = list_entry[deact_slot];
  assign deact_ok  = deact_event && el2_enabled &&
                     {1'b0, deact_slot} < list_entry_count;  // R21
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phys_deact_valid <= 1'b0;
      phys_deact_id    <= 13'h0000;
      eoi_maint        <= 1'b0;
    end else if (clk_en) begin
      phys_deact_valid <= 1'b0;
      eoi_maint        <= 1'b0;
      if (deact_ok && sel_entry[lvh_pkg::B_MAPS_PHYS]) begin
        // an unreachable id deactivates nothing
        phys_deact_valid <= sel_entry[lvh_pkg::PID_HI:lvh_pkg::PID_LO] <
                            lvh_pkg::PRIV_COUNT;  // R16 R20
        phys_deact_id <= sel_entry[lvh_pkg::PID_HI:lvh_pkg::PID_LO];  // R16
      end else if (deact_ok) begin
        eoi_maint <= sel_entry[lvh_pkg::B_EOI_REQ];  // R19
      end
    end
  end

  // checks next to the logic
  sequence s_os_redirect;
    take && acc_level == lvh_pkg::LVL_OS && el2_enabled &&
    nested_virt_enable && nested_redirect_enable && !legacy_mode_select;
  endsequence
  sequence s_redir_ctrl_ans;
    resp_valid && resp_outcome == lvh_pkg::LVH_REDIR &&
    resp_mem_offset == 12'h4C0;
  endsequence

  property p_user_undef;
    @(posedge core_clk) disable iff (rst)
      take && acc_level == lvh_pkg::LVL_USER |=>
      resp_valid && resp_outcome == lvh_pkg::LVH_UNDEF;
  endproperty
  a_user_undef: assert property (p_user_undef)  // R10
    else $error("lowest level access not undefined");

  property p_ctrl_redirect;
    @(posedge core_clk) disable iff (rst)
      s_os_redirect ##0 hit_ctrl |=> s_redir_ctrl_ans;
  endproperty
  a_ctrl_redirect: assert property (p_ctrl_redirect)  // R11
    else $error("control redirect offset wrong");

  property p_list_redirect;
    @(posedge core_clk) disable iff (rst)
      s_os_redirect ##0 (hit_list && !slot_missing) |=>
      resp_mem_offset == 12'h400 + 12'({$past(slot), 3'h0});
  endproperty
  a_list_redirect: assert property (p_list_redirect)  // R15
    else $error("list redirect offset wrong");

  property p_trap_class;
    @(posedge core_clk) disable iff (rst)
      resp_valid && resp_outcome == lvh_pkg::LVH_TRAP |->
      resp_class == 6'h18;
  endproperty
  a_trap_class: assert property (p_trap_class)  // R12
    else $error("trap class code wrong");

  property p_missing_slot;
    @(posedge core_clk) disable iff (rst)
      take && slot_missing |=> resp_outcome == lvh_pkg::LVH_UNDEF;
  endproperty
  a_missing_slot: assert property (p_missing_slot)  // R14
    else $error("missing list slot not undefined");

  property p_legacy_off;
    @(posedge core_clk) disable iff (rst)
      clk_en && !legacy_mode_select |=>
      !eff_enable && eff_maint_enable == 7'h00 && !eff_trap_sei;
  endproperty
  a_legacy_off: assert property (p_legacy_off)  // R2
    else $error("effective controls not forced off");

  property p_count_bump;
    @(posedge core_clk) disable iff (rst)
      clk_en && deact_event && !wr_ctrl |=>
      ctrl[31:27] == 5'($past(ctrl[31:27]) + 5'h01);
  endproperty
  a_count_bump: assert property (p_count_bump)  // R1
    else $error("deactivation counter did not advance");

  property p_ctrl_reserved;
    @(posedge core_clk) disable iff (rst)
      ##1 (ctrl & ~64'h0000_0000_F800_FCFF) == 64'h0;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)  // R22
    else $error("reserved control bits set");

  property p_dir_trap;
    @(posedge core_clk) disable iff (rst)
      clk_en && guest_valid && guest_write && guest_is_deact &&
      legacy_mode_select && ctrl[14] |=> guest_trap;
  endproperty
  a_dir_trap: assert property (p_dir_trap)  // R3
    else $error("deactivate write not trapped");

  property p_no_hyp_effect;
    @(posedge core_clk) disable iff (rst)
      clk_en && !el2_enabled |=> !phys_deact_valid && !eoi_maint;
  endproperty
  a_no_hyp_effect: assert property (p_no_hyp_effect)  // R21
    else $error("effect without hypervisor level");
endmodule // lvh_ctrl
